// ---- design/wp_pkg.sv ----
// Register map, field layout and reset values of the write-protect slice
package wp_pkg;
  localparam logic [7:0] OFF_CLEAR = 8'h00;
  localparam logic [7:0] OFF_SET = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
  localparam logic [31:0] PROT_RESET = 32'h00800000;
  localparam logic [31:0] PROT_FIXED = 32'h00800000;
  localparam logic [31:0] PROT_WMASK = 32'h000ffffe;
  localparam int EVENT_BIT_POS = 1;
  localparam int SERIAL_LSB = 2;
  localparam int SERIAL_MSB = 7;
  localparam int TIMER_LSB = 8;
  localparam int TIMER_MSB = 15;
  localparam int ADC_BIT_POS = 16;
  localparam int AC_BIT_POS = 17;
  localparam int DAC_BIT_POS = 18;
  localparam int TOUCH_BIT_POS = 19;
  localparam int IRQ_WIDTH = 2;
  localparam int IRQ_DOUBLE = 0;
  localparam int IRQ_DENIED = 1;
  localparam logic [IRQ_WIDTH-1:0] IRQ_STAT_RESET = 2'h0;
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;
endpackage

// ---- design/peripheral_access_guard.sv ----
// Checks a peripheral write against the protection vector
`timescale 1ns/1ps
module peripheral_access_guard #(
  parameter int NUM_BITS = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_BITS-1:0] prot_vec,
  input wire logic chk_valid,
  input wire logic [$clog2(NUM_BITS)-1:0] chk_index,
  output logic chk_deny_r,
  output logic chk_grant_r
);
  // A width that is not a power of two would let the index point past the vector
  if (NUM_BITS < 2 || NUM_BITS > 32 || (NUM_BITS & (NUM_BITS - 1)) != 0) begin : g_bad_width
    $error("NUM_BITS must be a power of two in 2..32");
  end

  logic chk_deny_nxt;
  logic chk_grant_nxt;

  always_comb begin
    chk_deny_nxt = chk_valid & prot_vec[chk_index];
    chk_grant_nxt = chk_valid & ~prot_vec[chk_index];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_deny_r <= 1'b0;
      chk_grant_r <= 1'b0;
    end else begin
      chk_deny_r <= chk_deny_nxt;
      chk_grant_r <= chk_grant_nxt;
    end
  end
endmodule

// ---- design/peripheral_write_protect_clear.sv ----
// APB write-protect controller: protection vector, clear/set views, errors, interrupt
// Overview of operation
// - Writing zero to a clear-register bit leaves that peripheral's protection unchanged.
// - Writing one clears protection; reads show 1 protected, 0 unprotected.
// - Clear register at 0x00, resets 0x00800000; event, analogue and touch bits placed.
// - Timer instances 0..7 protection at bits 8..15, read/write, reset zero.
// - Serial instances 0..5 protection at bits 2..7, read/write, reset zero.
// - Clear and set registers read back one shared protection vector.
// - Check of a write to a protected peripheral answers with chk_deny_r and sets the denied interrupt status.
// - Double protect or double unprotect returns an error response.
//
// The APB register port was decided locally.
`timescale 1ns/1ps
module peripheral_write_protect_clear (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready_r,
  output logic [31:0] prdata_r,
  output logic pslverr_r,
  input wire logic chk_valid,
  input wire logic [4:0] chk_index,
  output logic chk_deny_r,
  output logic chk_grant_r,
  output logic irq_r
);
  localparam int IRQ_W = wp_pkg::IRQ_WIDTH;
  localparam int NUM_SERIAL = wp_pkg::SERIAL_MSB - wp_pkg::SERIAL_LSB + 1;
  localparam int NUM_TIMER = wp_pkg::TIMER_MSB - wp_pkg::TIMER_LSB + 1;

  logic [31:0] prot_r;
  logic [31:0] prot_nxt;
  logic [31:0] prot_view;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_stat_nxt;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [IRQ_W-1:0] irq_mask_nxt;
  logic pready_nxt;
  logic [31:0] prdata_nxt;
  logic pslverr_nxt;
  logic irq_nxt;
  logic [31:0] lane_mask;
  logic [31:0] wbits;
  logic [31:0] clr_hit;
  logic [31:0] set_hit;
  logic access;
  logic commit;
  logic sel_clear;
  logic sel_set;
  logic sel_stat;
  logic sel_mask;
  logic wr_clear;
  logic wr_set;
  logic double_err;
  logic mapped;
  logic denied_pulse;
  logic event_system_bit;
  logic [NUM_SERIAL-1:0] serial_inst_bits;
  logic [NUM_TIMER-1:0] timer_inst_bits;
  logic adc_bit;
  logic ac_bit;
  logic dac_bit;
  logic touch_ctrl_bit;

  // Writable and constant bits must not overlap, or a bit would be both
  if ((wp_pkg::PROT_WMASK & wp_pkg::PROT_FIXED) != 32'h00000000) begin : g_bad_layout
    $error("Writable and fixed protection bits overlap");
  end

  // Both event sources need a status bit of their own
  if (IRQ_W <= wp_pkg::IRQ_DENIED || IRQ_W <= wp_pkg::IRQ_DOUBLE) begin : g_bad_irq
    $error("Interrupt status too narrow for its events");
  end

  // Named views of the peripheral groups held in the vector
  assign event_system_bit = prot_r[wp_pkg::EVENT_BIT_POS];
  assign serial_inst_bits = prot_r[wp_pkg::SERIAL_MSB:wp_pkg::SERIAL_LSB];
  assign timer_inst_bits = prot_r[wp_pkg::TIMER_MSB:wp_pkg::TIMER_LSB];
  assign adc_bit = prot_r[wp_pkg::ADC_BIT_POS];
  assign ac_bit = prot_r[wp_pkg::AC_BIT_POS];
  assign dac_bit = prot_r[wp_pkg::DAC_BIT_POS];
  assign touch_ctrl_bit = prot_r[wp_pkg::TOUCH_BIT_POS];

  // Only assigned peripheral bits are state; the rest read their constants
  always_comb begin
    prot_view = wp_pkg::PROT_FIXED;
    prot_view[wp_pkg::EVENT_BIT_POS] = event_system_bit;
    prot_view[wp_pkg::SERIAL_MSB:wp_pkg::SERIAL_LSB] = serial_inst_bits;
    prot_view[wp_pkg::TIMER_MSB:wp_pkg::TIMER_LSB] = timer_inst_bits;
    prot_view[wp_pkg::ADC_BIT_POS] = adc_bit;
    prot_view[wp_pkg::AC_BIT_POS] = ac_bit;
    prot_view[wp_pkg::DAC_BIT_POS] = dac_bit;
    prot_view[wp_pkg::TOUCH_BIT_POS] = touch_ctrl_bit;
  end

  // Byte-lane enables, one per strobe bit
  for (genvar lane = 0; lane < 4; lane++) begin : g_lane
    assign lane_mask[lane*8 +: 8] = {8{pstrb[lane]}};
  end

  // Bits outside the writable mask never reach the vector
  assign wbits = pwdata & lane_mask & wp_pkg::PROT_WMASK;

  // A one that clears an open bit or sets a protected bit is a double operation
  for (genvar b = 0; b < 32; b++) begin : g_hit
    assign clr_hit[b] = wbits[b] & ~prot_r[b];
    assign set_hit[b] = wbits[b] & prot_r[b];
  end

  always_comb begin
    sel_clear = (paddr == wp_pkg::OFF_CLEAR);
    sel_set = (paddr == wp_pkg::OFF_SET);
    sel_stat = (paddr == wp_pkg::OFF_IRQ_STAT);
    sel_mask = (paddr == wp_pkg::OFF_IRQ_MASK);
    mapped = sel_clear | sel_set | sel_stat | sel_mask;
    access = psel & penable;
    commit = access & pready_r & pwrite;
    wr_clear = commit & sel_clear;
    wr_set = commit & sel_set;
    // Protection vector only changes on a commit, so checking ahead is safe
    double_err = pwrite & ((sel_clear & (|clr_hit)) | (sel_set & (|set_hit)));
  end

  // Protection state
  always_comb begin
    prot_nxt = prot_r;
    if (wr_clear) begin
      prot_nxt = prot_r & ~wbits;
    end else if (wr_set) begin
      prot_nxt = prot_r | wbits;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_r <= wp_pkg::PROT_RESET;
    end else begin
      prot_r <= prot_nxt;
    end
  end

  // APB answer: one wait state, so data and error come from flops
  always_comb begin
    pready_nxt = access & ~pready_r;
    prdata_nxt = 32'h00000000;
    pslverr_nxt = 1'b0;
    if (access & ~pready_r) begin
      pslverr_nxt = ~mapped | double_err;
      if (!pwrite) begin
        unique case (paddr)
          wp_pkg::OFF_CLEAR: prdata_nxt = prot_view;
          wp_pkg::OFF_SET: prdata_nxt = prot_view;
          wp_pkg::OFF_IRQ_STAT: prdata_nxt = {{(32-IRQ_W){1'b0}}, irq_stat_r};
          wp_pkg::OFF_IRQ_MASK: prdata_nxt = {{(32-IRQ_W){1'b0}}, irq_mask_r};
          default: prdata_nxt = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Interrupt status and mask; a new event wins over a same-cycle clear
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    // Clears come first, so an event in the same cycle overrides them
    if (commit & sel_stat) begin
      irq_stat_nxt = irq_stat_r & ~(pwdata[IRQ_W-1:0] & lane_mask[IRQ_W-1:0]);
    end
    if (commit & sel_mask) begin
      irq_mask_nxt = (irq_mask_r & ~lane_mask[IRQ_W-1:0]) | (pwdata[IRQ_W-1:0] & lane_mask[IRQ_W-1:0]);
    end
    // The error answer is already out; the status keeps a record of it
    if (commit & pslverr_r & (sel_clear | sel_set)) begin
      irq_stat_nxt[wp_pkg::IRQ_DOUBLE] = 1'b1;
    end
    if (denied_pulse) begin
      irq_stat_nxt[wp_pkg::IRQ_DENIED] = 1'b1;
    end
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_r <= wp_pkg::IRQ_STAT_RESET;
      irq_mask_r <= wp_pkg::IRQ_MASK_RESET;
      irq_r <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Guard against writes to protected peripherals
  // Checked against the readable view, so fixed bits answer as they read
  peripheral_access_guard #(
    .NUM_BITS(32)
  ) u_guard (
    .pclk(pclk),
    .presetn(presetn),
    .prot_vec(prot_view),
    .chk_valid(chk_valid),
    .chk_index(chk_index),
    .chk_deny_r(chk_deny_r),
    .chk_grant_r(chk_grant_r)
  );

  assign denied_pulse = chk_deny_r;
endmodule

// ---- tb/wp_assertions.sv ----
// Port checks of the write-protect slice
`timescale 1ns/1ps
module wp_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready_r,
  input wire logic [31:0] prdata_r,
  input wire logic pslverr_r,
  input wire logic chk_valid,
  input wire logic chk_deny_r,
  input wire logic chk_grant_r
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  sequence s_wait; psel && penable && !pready_r; endsequence
  wire rd_p = pready_r && !pwrite && (paddr == 8'h00 || paddr == 8'h04);
  a_ready_delay: assert property (s_setup ##1 s_wait |=> pready_r) else $error("late ready");
  a_ready_pulse: assert property (pready_r |=> !pready_r) else $error("long ready");
  a_idle_data: assert property (!pready_r |-> prdata_r == 32'h0) else $error("idle data");
  a_fixed_bits: assert property (rd_p |-> (prdata_r & 32'hfff00001) == 32'h00800000) else $error("fixed");
  a_unmapped_err: assert property (pready_r && paddr[7:4] != 4'h0 |-> pslverr_r) else $error("unmapped");
  a_zero_write: assert property (pready_r && pwrite && paddr == 8'h00 && pwdata == 32'h0 |-> !pslverr_r)
    else $error("zero write");
  a_chk_answer: assert property (chk_valid |=> chk_deny_r != chk_grant_r) else $error("no answer");
  a_chk_quiet: assert property (!chk_valid |=> !chk_deny_r && !chk_grant_r) else $error("stray");
endmodule
bind peripheral_write_protect_clear wp_assertions i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready_r, .prdata_r, .pslverr_r, .chk_valid, .chk_deny_r, .chk_grant_r);

// ---- tb/tb_top.sv ----
// Bench with a reference model of the write-protect slice
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, chk_valid = 1'h0;
  logic pready_r, pslverr_r, chk_deny_r, chk_grant_r, irq_r;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata_r, m = 32'h00800000, lf = 32'h000178fe;
  logic [3:0] pstrb = 4'h0;
  logic [4:0] chk_index = 5'h0;
  logic [1:0] st = 2'h0, mk = 2'h0;
  int err_count = 0, compares = 0, cyc = 0;
  always #20 pclk = ~pclk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  peripheral_write_protect_clear i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .pready_r, .prdata_r, .pslverr_r, .chk_valid, .chk_index, .chk_deny_r, .chk_grant_r, .irq_r);
  task automatic cmp(input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      err_count++;
      $display("unexpected at %0t: %h vs %h", $time, s, x);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) if (++cyc == 5000) begin
    err_count++;
    end_of_test();
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] x, b, v;
    logic xe;
    b = d & {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    v = b & wp_pkg::PROT_WMASK;
    xe = !(a inside {8'h00, 8'h04, 8'h08, 8'h0c});
    x = xe ? 32'h0 : a == 8'h08 ? {30'h0, st} : a == 8'h0c ? {30'h0, mk} : m;
    if (w && a == 8'h00) xe = |(v & ~m);
    if (w && a == 8'h04) xe = |(v & m);
    if (w && a < 8'h08) m = a[2] ? m | v : m & ~v;
    if (w && xe && a < 8'h08) st[0] = 1'h1;
    if (w && a == 8'h08) st = st & ~b[1:0];
    if (w && a == 8'h0c) mk = (mk & ~{2{s[0]}}) | b[1:0];
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready_r !== 1'h1) @(posedge pclk);
    if (!w) cmp(prdata_r, x);
    cmp({31'h0, pslverr_r}, {31'h0, xe});
    psel <= 1'h0;
    penable <= 1'h0;
    @(negedge pclk);
    cmp({31'h0, irq_r}, {31'h0, |(st & mk)});
  endtask
  task automatic probe(input logic [4:0] k);
    @(posedge pclk);
    chk_valid <= 1'h1;
    chk_index <= k;
    @(posedge pclk);
    chk_valid <= 1'h0;
    @(negedge pclk);
    cmp({chk_deny_r, chk_grant_r}, {m[k], !m[k]});
    if (m[k]) st[1] = 1'h1;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'h1;
    for (int a = 0; a < 20; a += 4) acc(1'h0, a[7:0], 32'h0, 4'hf);
    acc(1'h1, 8'h10, 32'hffffffff, 4'hf);
    acc(1'h1, 8'h0c, 32'h3, 4'hf);
    acc(1'h1, 8'h04, 32'hffffffff, 4'hf);
    acc(1'h1, 8'h04, 32'h2, 4'h1);
    acc(1'h1, 8'h00, 32'h0, 4'hf);
    acc(1'h1, 8'h08, 32'h3, 4'hf);
    probe(5'h17);
    for (int i = 0; i < 40; i++) begin
      lf = lfsr_next(lf);
      acc(1'h1, {5'h0, lf[0], 2'h0}, lf, lf[7:4]);
      probe(lf[12:8]);
      acc(1'h0, {5'h0, lf[1], 2'h0}, 32'h0, 4'hf);
      if (lf[2]) begin
        acc(1'h0, 8'h08, 32'h0, 4'hf);
        acc(1'h1, 8'h08, 32'h3, 4'hf);
      end
      if (i == 20) begin
        acc(1'h1, 8'h0c, 32'h1, 4'hf);
        acc(1'h0, 8'h0c, 32'h0, 4'hf);
      end
    end
    // Mid-run reset must bring back the reset vector and a quiet interrupt
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    m = 32'h00800000;
    st = 2'h0;
    mk = 2'h0;
    for (int a = 0; a < 16; a += 4) acc(1'h0, a[7:0], 32'h0, 4'hf);
    end_of_test();
  end
endmodule
